/* File: ppss_chk_sva.sv */
// Port checker for the speed select block.
// Assumes binding into ppss_speed_select on its single clock.
`timescale 1ns/1ps
`default_nettype none
module ppss_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        core_phase_tick,
  input wire logic        core_double_speed,
  input wire logic        watchdog_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_core_pulse: assert property (core_phase_tick |=> !core_phase_tick [*5])
    else $error("core tick spacing");
  chk_wdg_pulse: assert property (watchdog_tick |=> !watchdog_tick [*5])
    else $error("watchdog tick spacing");
  chk_reset_std: assert property ($fell(srst) |-> !core_double_speed && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state after reset");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response held");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
    else $error("reserved read bits");
endmodule
bind ppss_speed_select ppss_chk i_chk (.clk(clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .core_phase_tick(core_phase_tick), .core_double_speed(core_double_speed), .watchdog_tick(watchdog_tick));
`default_nettype wire

/* File: ppss_defs.vh */
// Constants for the peripheral speed select block.
// Included by the design files; holds definitions only.
`ifndef PPSS_DEFS_VH
`define PPSS_DEFS_VH

// AXI4-Lite register map
`define PPSS_ADDR_W          4
`define PPSS_OFS_CTRL        4'h0
`define PPSS_OFS_STAT        4'h4

// Speed control field positions
`define PPSS_BIT_CORE        0
`define PPSS_BIT_T0          1
`define PPSS_BIT_T1          2
`define PPSS_BIT_T2          3
`define PPSS_BIT_SER         4
`define PPSS_BIT_PCA         5
`define PPSS_BIT_WDG         6
`define PPSS_CTRL_MASK       8'h7f
`define PPSS_CTRL_RESET      8'h00

// Oscillator periods per tick
`define PPSS_PER_STD         4'hc
`define PPSS_PER_FAST        4'h6
`define PPSS_PER_W           4
`define PPSS_CORE_LAST       3'h5

// Serial modes touched by the serial speed bit
`define PPSS_SER_MODE_SHIFT  2'h0
`define PPSS_SER_MODE_FIXED  2'h2

// AXI responses
`define PPSS_RESP_OKAY       2'h0
`define PPSS_RESP_SLVERR     2'h2

`endif

/* File: ppss_speed_select.v */
// Clock speed selection: core and peripheral tick strobes.
// Assumes clk is the oscillator input; AXI4-Lite master on same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ppss_defs.vh"

module ppss_speed_select (
  input  wire        clk,
  input  wire        srst,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  serial_mode,
  output reg         core_phase_tick,
  output reg         core_double_speed,
  output wire        timer_zero_tick,
  output wire        timer_one_tick,
  output wire        timer_two_tick,
  output wire        serial_tick,
  output wire        counter_array_tick,
  output wire        watchdog_tick
);

  // ****************************************
  // Register slave
  // ****************************************
  reg  [7:0]  speed_select_control;
  reg         div2_phase;
  reg         aw_held;
  reg         w_held;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held;

  always @(posedge clk) begin
    if (srst) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 4'h0;
      w_data   <= 32'h0;
      w_strb   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PPSS_RESP_OKAY;
      speed_select_control <= `PPSS_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `PPSS_OFS_CTRL && w_strb[0]) begin
          speed_select_control <= w_data[7:0] & `PPSS_CTRL_MASK;
          s_axi_bresp <= `PPSS_RESP_OKAY;
        end else if (aw_addr == `PPSS_OFS_CTRL || aw_addr == `PPSS_OFS_STAT) begin
          s_axi_bresp <= `PPSS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PPSS_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `PPSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `PPSS_OFS_CTRL: begin
          s_axi_rdata <= {24'h0, speed_select_control};
          s_axi_rresp <= `PPSS_RESP_OKAY;
        end
        `PPSS_OFS_STAT: begin
          s_axi_rdata <= {30'h0, div2_phase, core_double_speed};
          s_axi_rresp <= `PPSS_RESP_OKAY;
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PPSS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Core clock path
  // ****************************************
  reg  [2:0] core_count;
  wire [2:0] core_last;

  always @(posedge clk) begin
    if (srst) begin
      div2_phase <= 1'b0;
    end else begin
      div2_phase <= !div2_phase;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      core_double_speed <= 1'b0;
    end else if (!div2_phase) begin
      core_double_speed <= speed_select_control[`PPSS_BIT_CORE];
    end
  end

  // 12 periods standard, 6 periods double
  assign core_last = `PPSS_CORE_LAST;

  always @(posedge clk) begin
    if (srst) begin
      core_count      <= 3'h0;
      core_phase_tick <= 1'b0;
    end else if (!core_double_speed && !div2_phase) begin
      core_count      <= core_count;
      core_phase_tick <= 1'b0;
    end else if (core_count >= core_last) begin
      core_count      <= 3'h0;
      core_phase_tick <= 1'b1;
    end else begin
      core_count      <= core_count + 3'h1;
      core_phase_tick <= 1'b0;
    end
  end

  // ****************************************
  // Peripheral ticks
  // ****************************************
  wire [5:0] periph_sel;
  wire [5:0] periph_slow;
  wire [5:0] periph_tick;
  wire       serial_affected;

  assign serial_affected = (serial_mode == `PPSS_SER_MODE_SHIFT) ||
                           (serial_mode == `PPSS_SER_MODE_FIXED);

  assign periph_sel = {speed_select_control[`PPSS_BIT_WDG],
                       speed_select_control[`PPSS_BIT_PCA],
                       speed_select_control[`PPSS_BIT_SER] | !serial_affected,
                       speed_select_control[`PPSS_BIT_T2],
                       speed_select_control[`PPSS_BIT_T1],
                       speed_select_control[`PPSS_BIT_T0]};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_periph
      assign periph_slow[gi] = !core_double_speed || periph_sel[gi];
      ppss_tick_gen u_tick (
        .clk  (clk),
        .srst (srst),
        .slow (periph_slow[gi]),
        .tick (periph_tick[gi])
      );
    end
  endgenerate

  assign timer_zero_tick    = periph_tick[0];
  assign timer_one_tick     = periph_tick[1];
  assign timer_two_tick     = periph_tick[2];
  assign serial_tick        = periph_tick[3];
  assign counter_array_tick = periph_tick[4];
  assign watchdog_tick      = periph_tick[5];

endmodule
`default_nettype wire

/* File: ppss_tick_gen.v */
// One tick strobe generator with selectable period.
// Assumes one clock domain; a period change applies at once to the count in progress.
`timescale 1ns/1ps
`default_nettype none
`include "ppss_defs.vh"

module ppss_tick_gen (
  input  wire       clk,
  input  wire       srst,
  input  wire       slow,
  output reg        tick
);

  reg  [`PPSS_PER_W-1:0] count;
  wire [`PPSS_PER_W-1:0] last;

  assign last = slow ? (`PPSS_PER_STD - 4'h1) : (`PPSS_PER_FAST - 4'h1);

  always @(posedge clk) begin
    if (srst) begin
      count <= 4'h0;
      tick  <= 1'b0;
    end else if (count >= last) begin
      count <= 4'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 4'h1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: tb.sv */
// Bench for the speed select block over AXI4-Lite.
// Assumes a 25 MHz clock and the ppss_chk checker bound in.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0, srst = 1'b1, av = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [3:0]  aa = 4'h0, ra = 4'h0, ws = 4'h0;
  logic [31:0] wd = 32'h0, d;
  logic [1:0]  sm = 2'h0;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         awr, wyr, bv, arr, rv, cds;
  wire  [6:0]  tk;
  int          err_count = 0, n_compared = 0, cyc = 0;
  ppss_speed_select i_dut (.clk(clk), .srst(srst), .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wyr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .serial_mode(sm),
    .core_phase_tick(tk[0]), .core_double_speed(cds), .timer_zero_tick(tk[1]), .timer_one_tick(tk[2]),
    .timer_two_tick(tk[3]), .serial_tick(tk[4]), .counter_array_tick(tk[5]), .watchdog_tick(tk[6]));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      conclude;
    end
  end
  task chk(input string nm, input [31:0] s, input [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wr(input [3:0] a, input [31:0] v, input [3:0] s, input [1:0] eb);
    @(posedge clk);
    aa <= a;
    wd <= v;
    ws <= s;
    av <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    fork
      begin do @(posedge clk); while (!awr); av <= 1'b0; end
      begin do @(posedge clk); while (!wyr); wv <= 1'b0; end
    join
    do @(posedge clk); while (!bv);
    bry <= 1'b0;
    chk("bresp", bresp, eb);
  endtask
  task rd(input [3:0] a, input [1:0] e);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rry <= 1'b0;
    d = rdata;
    chk("rresp", rresp, e);
  endtask
  // Skips a settling period, then counts clocks between two ticks
  task gap(input int i, input [7:0] e);
    logic [7:0] n;
    repeat (2) do @(negedge clk); while (tk[i] !== 1'b1);
    n = 0;
    do begin @(negedge clk); n++; end while (tk[i] !== 1'b1);
    chk("tick gap", n, e);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0, 2'h0);
    chk("ctrl", d, 0);
    chk("core speed", cds, 0);
    for (int i = 0; i < 7; i++) gap(i, 12);
    wr(4'h0, 32'h7e, 4'h1, 2'h0);
    for (int i = 0; i < 7; i++) gap(i, 12);
    wr(4'h0, 32'hff, 4'h1, 2'h0);
    rd(4'h0, 2'h0);
    chk("ctrl", d, 32'h7f);
    gap(0, 6);
    for (int i = 1; i < 7; i++) gap(i, 12);
    rd(4'h4, 2'h0);
    chk("status core", d[0], 1);
    chk("core speed", cds, 1);
    for (int k = 1; k < 7; k++) begin
      wr(4'h0, 32'h1 | (32'h1 << k), 4'h1, 2'h0);
      for (int i = 1; i < 7; i++) gap(i, i == k ? 12 : 6);
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      sm <= m[1:0];
      gap(4, m[0] ? 12 : 6);
    end
    wr(4'h0, 32'h0, 4'h0, 2'h0);
    rd(4'h0, 2'h0);
    chk("ctrl", d, 32'h41);
    wr(4'h4, 32'h0, 4'h1, 2'h0);
    wr(4'h8, 32'h0, 4'h1, 2'h2);
    rd(4'h8, 2'h2);
    chk("unmapped", d, 0);
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0, 2'h0);
    chk("ctrl", d, 0);
    chk("core speed", cds, 0);
    conclude;
  end
endmodule
`default_nettype wire
